/* File: rtl/lsm_defs.vh */
// constants of the limit switch monitor: parameter offsets, field codes, reset values
// assumes inclusion by the monitor module only
`ifndef LSM_DEFS_VH
`define LSM_DEFS_VH

// ************************************************
// parameter offsets
// ************************************************
`define LSM_OFS_NEG_EVAL      16'h061E
`define LSM_OFS_POS_EVAL      16'h0620
`define LSM_OFS_SUPPRESS      16'h064A
`define LSM_OFS_DIRECT_OUT    16'h0822

// ************************************************
// reset values
// ************************************************
`define LSM_RST_NEG_EVAL      16'h0001
`define LSM_RST_POS_EVAL      16'h0001
`define LSM_RST_SUPPRESS      16'h0000
`define LSM_RST_DIRECT_OUT    16'h0000

// ************************************************
// evaluation codes
// ************************************************
`define LSM_EVAL_INACTIVE     16'h0000
`define LSM_EVAL_NC           16'h0001
`define LSM_EVAL_NO           16'h0002

// ************************************************
// suppression field positions
// ************************************************
`define LSM_SUP_POS_BIT       0
`define LSM_SUP_NEG_BIT       1

// ************************************************
// quick stop reaction codes
// ************************************************
`define LSM_QS_TORQUE_FAULT   16'hFFFE
`define LSM_QS_DECEL_FAULT    16'hFFFF
`define LSM_QS_DECEL_HOLD     16'h0006
`define LSM_QS_TORQUE_HOLD    16'h0007

// ************************************************
// error class
// ************************************************
`define LSM_ERR_CLASS_LIMIT   2'h1
`define LSM_ERR_CLASS_NONE    2'h0

// ************************************************
// timing counts
// ************************************************
`define LSM_PIN_SETTLE        2'h2

`endif

/* File: rtl/lsm_limit_switch_monitor.v */
// hardware limit switch monitor with quick stop request and direct digital outputs
// assumes limit contacts arrive asynchronously; all other inputs come from logic on clk
`timescale 1ns/1ps
`include "lsm_defs.vh"

// ************************************************
// Overview of operation
// - writes only reach free-use assigned outputs
// - sixteen bit output word, bit 0 first
// - tripped limit during movement issues quick stop
// - limit trip records class-1 error
// - error latched until fault reset clears it
// - after trip only opposite direction allowed
// - motion toward tripped switch raises new error
// - positive evaluation: 0 off, 1 NC, 2 NO
// - negative evaluation: 0 off, 1 NC, 2 NO
// - evaluation writes only with power stage off
// - suppression: 0 none, 1 pos, 2 neg, 3 both
// - suppression write takes effect at once
// - suppressed switch gives no trip; a side blocked earlier still errors on motion toward it
// - quick stop follows selected reaction setting
// - reaction codes -2, -1, 6, 7 decoded
// ************************************************

module lsm_limit_switch_monitor #(
    parameter OUT_COUNT = 16
) (
    input  wire                 clk,
    input  wire                 srst,
    input  wire                 posLimitInput,
    input  wire                 negLimitInput,
    input  wire                 posLimitAssigned,
    input  wire                 negLimitAssigned,
    input  wire [OUT_COUNT-1:0] outputFreeUse,
    input  wire                 powerStageEnable,
    input  wire                 moveCmdPos,
    input  wire                 moveCmdNeg,
    input  wire                 faultReset,
    input  wire [15:0]          quickstopReactionCode,
    input  wire                 parWrite,
    input  wire                 parRead,
    input  wire [15:0]          parAddr,
    input  wire [15:0]          parWrData,
    output reg  [15:0]          parRdData,
    output reg                  parAck,
    output reg                  parRefused,
    output reg  [OUT_COUNT-1:0] digitalOut,
    output reg                  quickStopReq,
    output reg                  stopTorqueRamp,
    output reg                  stopToFault,
    output reg                  errorActive,
    output reg  [1:0]           errorClass,
    output reg                  errorEvent,
    output reg                  posBlocked,
    output reg                  negBlocked
);

// ************************************************
// helper functions
// ************************************************
    function tripOf;
        input [15:0] evalCode;
        input        level;
        begin
            case (evalCode)
                `LSM_EVAL_NC: tripOf = ~level;
                `LSM_EVAL_NO: tripOf = level;
                default:      tripOf = 1'b0;
            endcase
        end
    endfunction

    function [1:0] reactionOf;  // {torque, fault}
        input [15:0] code;
        begin
            case (code)
                `LSM_QS_TORQUE_FAULT: reactionOf = 2'h3;
                `LSM_QS_DECEL_FAULT:  reactionOf = 2'h1;
                `LSM_QS_DECEL_HOLD:   reactionOf = 2'h0;
                `LSM_QS_TORQUE_HOLD:  reactionOf = 2'h2;
                default:              reactionOf = 2'h2;
            endcase
        end
    endfunction

// ************************************************
// pin synchronisers
// ************************************************
    reg        posMeta;
    reg        posSync;
    reg        negMeta;
    reg        negSync;

    always @(posedge clk) begin
        if (srst) begin
            posMeta <= 1'b0;
            posSync <= 1'b0;
            negMeta <= 1'b0;
            negSync <= 1'b0;
        end else begin
            posMeta <= posLimitInput;
            posSync <= posMeta;
            negMeta <= negLimitInput;
            negSync <= negMeta;
        end
    end

// ************************************************
// pin settle window
// ************************************************
    // synchronisers leave reset at 0, a false trip for a closed contact
    reg [1:0]  pinSettle;
    wire       pinsValid = (pinSettle == `LSM_PIN_SETTLE);

    always @(posedge clk) begin
        if (srst) begin
            pinSettle <= 2'h0;
        end else if (!pinsValid) begin
            pinSettle <= pinSettle + 2'h1;
        end
    end

// ************************************************
// parameter registers
// ************************************************
    localparam [15:0] RST_OUT_WORD = `LSM_RST_DIRECT_OUT;

    reg [15:0] posEval;
    reg [15:0] negEval;
    reg [15:0] posEvalActive;
    reg [15:0] negEvalActive;
    reg [15:0] suppress;
    reg        powerPrev;

    wire       evalAddr   = (parAddr == `LSM_OFS_POS_EVAL) || (parAddr == `LSM_OFS_NEG_EVAL);
    wire       evalLocked = parWrite && evalAddr && powerStageEnable;
    wire       wrOk       = parWrite && !evalLocked;
    wire       powerRise  = powerStageEnable && !powerPrev;
    wire [OUT_COUNT-1:0] wrBits = parWrData[OUT_COUNT-1:0];

    always @(posedge clk) begin
        if (srst) begin
            posEval <= `LSM_RST_POS_EVAL;
            negEval <= `LSM_RST_NEG_EVAL;
        end else begin
            if (wrOk && parAddr == `LSM_OFS_POS_EVAL) begin
                posEval <= parWrData;
            end
            if (wrOk && parAddr == `LSM_OFS_NEG_EVAL) begin
                negEval <= parWrData;
            end
        end
    end

// ************************************************
// power stage enable edge
// ************************************************
    always @(posedge clk) begin
        if (srst) begin
            posEvalActive <= `LSM_RST_POS_EVAL;
            negEvalActive <= `LSM_RST_NEG_EVAL;
            powerPrev     <= 1'b0;
        end else begin
            powerPrev <= powerStageEnable;
            if (powerRise) begin
                posEvalActive <= posEval;
                negEvalActive <= negEval;
            end
        end
    end

    // a fresh enable applies the written codes in its own cycle
    wire [15:0] posEvalUse = powerRise ? posEval : posEvalActive;
    wire [15:0] negEvalUse = powerRise ? negEval : negEvalActive;

// ************************************************
// suppression
// ************************************************
    always @(posedge clk) begin
        if (srst) begin
            suppress <= `LSM_RST_SUPPRESS;
        end else if (wrOk && parAddr == `LSM_OFS_SUPPRESS) begin
            suppress <= parWrData;
        end
    end

// ************************************************
// direct outputs
// ************************************************
    always @(posedge clk) begin
        if (srst) begin
            digitalOut <= RST_OUT_WORD[OUT_COUNT-1:0];
        end else if (wrOk && parAddr == `LSM_OFS_DIRECT_OUT) begin
            digitalOut <= (digitalOut & ~outputFreeUse) | (wrBits & outputFreeUse);
        end
    end

// ************************************************
// parameter read and acknowledge
// ************************************************
    reg [15:0] next_parRdData;

    always @* begin
        next_parRdData = 16'h0000;
        case (parAddr)
            `LSM_OFS_POS_EVAL:   next_parRdData = posEval;
            `LSM_OFS_NEG_EVAL:   next_parRdData = negEval;
            `LSM_OFS_SUPPRESS:   next_parRdData = suppress;
            `LSM_OFS_DIRECT_OUT: next_parRdData[OUT_COUNT-1:0] = digitalOut;
            default:             next_parRdData = 16'h0000;
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            parRdData  <= 16'h0000;
            parAck     <= 1'b0;
            parRefused <= 1'b0;
        end else begin
            parAck     <= parWrite || parRead;
            parRefused <= evalLocked;
            if (parRead) begin
                parRdData <= next_parRdData;
            end
        end
    end

// ************************************************
// trip evaluation
// ************************************************
    wire posSup  = suppress[`LSM_SUP_POS_BIT];
    wire negSup  = suppress[`LSM_SUP_NEG_BIT];
    wire posTrip = pinsValid && posLimitAssigned && !posSup && tripOf(posEvalUse, posSync);
    wire negTrip = pinsValid && negLimitAssigned && !negSup && tripOf(negEvalUse, negSync);
    wire moving  = powerStageEnable && (moveCmdPos || moveCmdNeg);

    // a fresh trip while moving, or motion toward a blocked side
    wire posFresh  = posTrip && !posBlocked && moving;
    wire negFresh  = negTrip && !negBlocked && moving;
    wire posToward = posBlocked && moveCmdPos;
    wire negToward = negBlocked && moveCmdNeg;
    wire posCause  = posFresh || posToward;
    wire negCause  = negFresh || negToward;
    wire anyCause = posCause || negCause;
    wire [1:0] reaction = reactionOf(quickstopReactionCode);

// ************************************************
// error and quick stop
// ************************************************
    always @(posedge clk) begin
        if (srst) begin
            errorActive <= 1'b0;
            errorClass  <= `LSM_ERR_CLASS_NONE;
            errorEvent  <= 1'b0;
        end else begin
            errorEvent <= anyCause;
            if (anyCause) begin
                errorActive <= 1'b1;
                errorClass  <= `LSM_ERR_CLASS_LIMIT;
            end else if (faultReset) begin
                errorActive <= 1'b0;
                errorClass  <= `LSM_ERR_CLASS_NONE;
            end
        end
    end

    // ramp and end state follow the code in force at the trip
    always @(posedge clk) begin
        if (srst) begin
            quickStopReq   <= 1'b0;
            stopTorqueRamp <= 1'b0;
            stopToFault    <= 1'b0;
        end else if (anyCause) begin
            quickStopReq   <= 1'b1;
            stopTorqueRamp <= reaction[1];
            stopToFault    <= reaction[0];
        end else if (faultReset) begin
            quickStopReq <= 1'b0;
        end
    end

// ************************************************
// direction blocking
// ************************************************
    always @(posedge clk) begin
        if (srst) begin
            posBlocked <= 1'b0;
            negBlocked <= 1'b0;
        end else begin
            if (posCause) begin
                posBlocked <= 1'b1;
            end else if (!posTrip && !errorActive) begin
                posBlocked <= 1'b0;
            end
            if (negCause) begin
                negBlocked <= 1'b1;
            end else if (!negTrip && !errorActive) begin
                negBlocked <= 1'b0;
            end
        end
    end

endmodule // lsm_limit_switch_monitor

/* File: test/lsm_contact_model.sv */
// model of the two limit switch contacts seen by the monitor
// assumes the bench sets hit levels and the contact type of each switch
`timescale 1ns/1ps
// ************************************************
// contact levels
// ************************************************
module lsm_contact_model (
    input  wire posHit,
    input  wire negHit,
    input  wire posNc,
    input  wire negNc,
    output wire posLimitInput,
    output wire negLimitInput
);
    // a closed-type contact opens when hit, an open-type contact closes
    assign posLimitInput = posNc ? !posHit : posHit;
    assign negLimitInput = negNc ? !negHit : negHit;
endmodule // lsm_contact_model

/* File: test/lsm_check_monitor.sv */
// port checker of the limit switch monitor
// assumes one clock clk and synchronous active high reset srst
`timescale 1ns/1ps
// ************************************************
// checker
// ************************************************
module lsm_check_monitor #(
    parameter OUT_COUNT = 16
) (
    input wire                 clk,
    input wire                 srst,
    input wire                 parWrite,
    input wire                 parRead,
    input wire                 powerStageEnable,
    input wire                 faultReset,
    input wire                 moveCmdPos,
    input wire                 moveCmdNeg,
    input wire [15:0]          parAddr,
    input wire [15:0]          parWrData,
    input wire [15:0]          quickstopReactionCode,
    input wire [OUT_COUNT-1:0] outputFreeUse,
    input wire [OUT_COUNT-1:0] digitalOut,
    input wire                 parAck,
    input wire                 parRefused,
    input wire                 quickStopReq,
    input wire                 stopTorqueRamp,
    input wire                 stopToFault,
    input wire                 errorActive,
    input wire                 errorEvent,
    input wire                 posBlocked,
    input wire                 negBlocked,
    input wire [1:0]           errorClass
);
    wire [15:0] qc = quickstopReactionCode;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ack_after_req_a: assert property ((parWrite || parRead) |=> parAck) else $error("no ack after access");
    ack_has_cause_a: assert property (parAck |-> $past(parWrite || parRead)) else $error("ack without access");
    eval_refused_a: assert property (parWrite && powerStageEnable && (parAddr == 16'h061E ||
        parAddr == 16'h0620) |=> parRefused) else $error("eval write not refused");
    out_mask_a: assert property (parWrite && parAddr == 16'h0822 |=> digitalOut ==
        (($past(parWrData[OUT_COUNT-1:0]) & $past(outputFreeUse)) | ($past(digitalOut) & ~$past(outputFreeUse))))
        else $error("output bits wrong");
    stop_with_error_a: assert property (errorEvent |-> errorActive && quickStopReq) else $error("no stop");
    error_class_a: assert property (errorClass == {1'b0, errorActive}) else $error("class wrong");
    stop_kind_a: assert property ($rose(quickStopReq) |-> {stopTorqueRamp, stopToFault} ==
        ($past(qc) == 16'hFFFE ? 2'h3 : $past(qc) == 16'hFFFF ? 2'h1 : $past(qc) == 16'h0006 ? 2'h0 : 2'h2))
        else $error("stop kind wrong");
    fault_clear_a: assert property (faultReset |=> !errorActive || errorEvent) else $error("no clear");
    toward_block_a: assert property (posBlocked && moveCmdPos |=> errorEvent) else $error("no new error");
    neg_toward_a: assert property (negBlocked && moveCmdNeg |=> errorEvent) else $error("no new neg error");
endmodule // lsm_check_monitor
bind lsm_limit_switch_monitor lsm_check_monitor #(.OUT_COUNT(OUT_COUNT)) chk_u (
    .clk(clk), .srst(srst), .parWrite(parWrite), .parRead(parRead), .powerStageEnable(powerStageEnable),
    .faultReset(faultReset), .moveCmdPos(moveCmdPos), .moveCmdNeg(moveCmdNeg), .parAddr(parAddr),
    .parWrData(parWrData), .quickstopReactionCode(quickstopReactionCode), .outputFreeUse(outputFreeUse),
    .digitalOut(digitalOut), .parAck(parAck), .parRefused(parRefused), .quickStopReq(quickStopReq),
    .stopTorqueRamp(stopTorqueRamp), .stopToFault(stopToFault), .errorActive(errorActive),
    .errorEvent(errorEvent), .posBlocked(posBlocked), .negBlocked(negBlocked), .errorClass(errorClass)
);

/* File: test/tb_top.sv */
// self-checking bench of the limit switch monitor
// assumes the contact model and the bound checker are compiled before it
`timescale 1ns/1ps
// ************************************************
// bench
// ************************************************
module tb_top;
    reg         clk, srst, posLimitAssigned, negLimitAssigned, powerStageEnable, moveCmdPos, moveCmdNeg;
    reg         faultReset, parWrite, parRead, posHit, negHit, posNc, negNc, refVal;
    reg  [15:0] outputFreeUse, quickstopReactionCode, parAddr, parWrData, rdVal;
    wire        posLimitInput, negLimitInput, parAck, parRefused, quickStopReq, stopTorqueRamp, stopToFault;
    wire        errorActive, errorEvent, posBlocked, negBlocked;
    wire [15:0] parRdData, digitalOut;
    wire [1:0]  errorClass;
    integer     fail_count, compares, i, n;
    reg  [15:0] codes [0:3];
    reg  [1:0]  kinds [0:3];
    lsm_limit_switch_monitor #(.OUT_COUNT(16)) dut_u (
        .clk(clk), .srst(srst), .posLimitInput(posLimitInput), .negLimitInput(negLimitInput),
        .posLimitAssigned(posLimitAssigned), .negLimitAssigned(negLimitAssigned), .outputFreeUse(outputFreeUse),
        .powerStageEnable(powerStageEnable), .moveCmdPos(moveCmdPos), .moveCmdNeg(moveCmdNeg),
        .faultReset(faultReset), .quickstopReactionCode(quickstopReactionCode), .parWrite(parWrite),
        .parRead(parRead), .parAddr(parAddr), .parWrData(parWrData), .parRdData(parRdData), .parAck(parAck),
        .parRefused(parRefused), .digitalOut(digitalOut), .quickStopReq(quickStopReq),
        .stopTorqueRamp(stopTorqueRamp), .stopToFault(stopToFault), .errorActive(errorActive),
        .errorClass(errorClass), .errorEvent(errorEvent), .posBlocked(posBlocked), .negBlocked(negBlocked)
    );
    lsm_contact_model part_u (
        .posHit(posHit), .negHit(negHit), .posNc(posNc), .negNc(negNc),
        .posLimitInput(posLimitInput), .negLimitInput(negLimitInput)
    );
    initial begin
        clk = 0;
        forever #5 clk = !clk;
    end
    task tick; begin @(posedge clk); #1; end endtask
    task close_out; begin
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end endtask
    task chk(input [8*8:1] name, input [15:0] exp, input [15:0] got); begin
        compares = compares + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, got);
        end
    end endtask
    task access(input w, input [15:0] a, input [15:0] d); begin
        parWrite = w; parRead = !w; parAddr = a; parWrData = d;
        tick;
        parWrite = 0; parRead = 0;
        for (n = 0; n < 4 && parAck !== 1'b1; n = n + 1) tick;
        if (parAck !== 1'b1) begin fail_count = fail_count + 1; close_out; end
        rdVal = parRdData; refVal = parRefused;
        tick;
    end endtask
    task wait_err; begin
        for (n = 0; n < 8 && errorActive !== 1'b1; n = n + 1) tick;
        if (errorActive !== 1'b1) begin fail_count = fail_count + 1; close_out; end
    end endtask
    initial begin
        codes[0] = 16'hFFFE; codes[1] = 16'hFFFF; codes[2] = 16'h0006; codes[3] = 16'h0007;
        kinds[0] = 2'h3; kinds[1] = 2'h1; kinds[2] = 2'h0; kinds[3] = 2'h2;
        srst = 1; posLimitAssigned = 1; negLimitAssigned = 1; powerStageEnable = 0; moveCmdPos = 0;
        moveCmdNeg = 0; faultReset = 0; parWrite = 0; parRead = 0; posHit = 0; negHit = 0; posNc = 1;
        negNc = 1; outputFreeUse = 16'h00FF; quickstopReactionCode = 16'h0007; parAddr = 0; parWrData = 0;
        fail_count = 0; compares = 0;
        repeat (20) tick;
        srst = 0;
        access(0, 16'h061E, 0); chk("negEval", 16'h0001, rdVal);
        access(0, 16'h0620, 0); chk("posEval", 16'h0001, rdVal);
        access(0, 16'h064A, 0); chk("suppress", 16'h0000, rdVal);
        access(0, 16'h0100, 0); chk("unmapped", 16'h0000, rdVal);
        access(1, 16'h0822, 16'hA5A5); chk("outputs", 16'h00A5, digitalOut);
        outputFreeUse = 16'hFF00;
        access(1, 16'h0822, 16'h0F0F); chk("outputs", 16'h0FA5, digitalOut);
        access(0, 16'h0822, 0); chk("outRead", 16'h0FA5, rdVal);
        $display("test registers and outputs done");
        powerStageEnable = 1;
        access(1, 16'h0620, 16'h0002); chk("refused", 16'h0001, {15'h0, refVal});
        access(0, 16'h0620, 0); chk("posEval", 16'h0001, rdVal);
        for (i = 0; i < 4; i = i + 1) begin
            quickstopReactionCode = codes[i]; posHit = 1; moveCmdPos = 1;
            wait_err;
            chk("flags", {11'h1, 3'b110, kinds[i]},
                {9'h0, errorClass, quickStopReq, posBlocked, negBlocked, stopTorqueRamp, stopToFault});
            moveCmdPos = 0; tick; faultReset = 1; tick; faultReset = 0; moveCmdNeg = 1; tick; tick;
            chk("held", 16'h0001, {14'h0, errorActive, posBlocked});
            moveCmdNeg = 0; moveCmdPos = 1; tick; tick;
            chk("again", 16'h0001, {15'h0, errorActive});
            moveCmdPos = 0; posHit = 0; repeat (3) tick; faultReset = 1; tick; faultReset = 0; tick; tick;
            chk("cleared", 16'h0000, {14'h0, errorActive, posBlocked});
        end
        $display("test trip and reaction codes done");
        access(1, 16'h064A, 16'h0001); posHit = 1; moveCmdPos = 1; repeat (6) tick;
        chk("suppress", 16'h0000, {13'h0, errorActive, quickStopReq, posBlocked});
        moveCmdPos = 0; posHit = 0; repeat (3) tick;
        access(1, 16'h064A, 16'h0000);
        posLimitAssigned = 0; posHit = 1; moveCmdPos = 1; repeat (6) tick;
        chk("unassign", 16'h0000, {14'h0, errorActive, posBlocked});
        moveCmdPos = 0; posHit = 0; posLimitAssigned = 1; repeat (3) tick;
        powerStageEnable = 0; negNc = 0;
        access(1, 16'h061E, 16'h0002); chk("refused", 16'h0000, {15'h0, refVal});
        access(1, 16'h0620, 16'h0000);
        powerStageEnable = 1; posHit = 1; moveCmdPos = 1; moveCmdNeg = 1; repeat (5) tick;
        chk("quiet", 16'h0000, {15'h0, errorActive});
        moveCmdPos = 0; negHit = 1;
        wait_err;
        chk("negTrip", 16'h0002, {14'h0, negBlocked, posBlocked});
        $display("test suppression and evaluation codes done");
        close_out;
    end
endmodule // tb_top
